// *** dv/itam_host_model.sv ***
// Purpose: Host side issuing I/O cycles to the register block
// Assumes: One access at a time, strobe one cycle wide
// Notes: Released lines show inverted values so stale data never matches
`timescale 1ns/1ps
`default_nettype none
module itam_host_model (
  // Clock and register base
  input wire logic mclk,
  input wire itam_pkg::itam_word_t base,
  // I/O cycle
  output itam_pkg::itam_word_t io_addr,
  output logic io_rd,
  output logic io_wr,
  output logic [1:0] io_be,
  output itam_pkg::itam_word_t io_wdata,
  // Answer
  input wire itam_pkg::itam_word_t io_rdata_r,
  input wire logic io_ack_r
);
  import itam_pkg::*;
  // Idle bus at time zero
  initial begin
    io_addr = 16'hFFFF;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_be = 2'h0;
    io_wdata = 16'h0000;
  end
  // One access: strobe for one cycle, answer taken the cycle after
  task automatic acc(input logic w, input itam_word_t ofs,
    input itam_word_t d, input logic [1:0] be,
    output itam_word_t q, output logic ack);
    @(posedge mclk);
    #1;
    io_addr = base + ofs;
    io_wr = w;
    io_rd = !w;
    io_be = be;
    io_wdata = d; // Ones clear flags
    @(posedge mclk);
    #1;
    q = io_rdata_r;
    ack = io_ack_r;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_addr = ~io_addr;
    io_wdata = ~io_wdata;
  endtask
endmodule
`default_nettype wire

// *** dv/test_io_trap_activity_monitor.sv ***
// Purpose: Self-checking bench for the trap and activity monitor
// Assumes: Hits are pulses, PIRQ pins held low a few cycles
// Notes: Register base is fixed; each scenario is its own task
`timescale 1ns/1ps
`default_nettype none
`include "itam_regs.svh"
module test_io_trap_activity_monitor;
  import itam_pkg::*;
  logic mclk, rst, io_rd, io_wr, io_ack_r, smi_n, fwd;
  logic [1:0] io_be;
  itam_word_t base, io_addr, io_wdata, io_rdata_r, dta, q;
  itam_mon_t mon;
  logic [12:0] src;
  logic [7:0] pirq_n;
  logic a;
  int num_errors, num_checks;
  // Clock, 4 ns period
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  itam_host_model u_host (.mclk(mclk), .base(base), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_be(io_be), .io_wdata(io_wdata),
    .io_rdata_r(io_rdata_r), .io_ack_r(io_ack_r));
  itam_top u_dut (.mclk(mclk), .rst(rst), .power_mgmt_io_base(base),
    .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_be(io_be),
    .io_wdata(io_wdata), .io_rdata_r(io_rdata_r), .io_ack_r(io_ack_r),
    .monitor_hit(mon), .fm_sound_hit(src[12]),
    .keyboard_ctrl_hit(src[11]), .music_port_hit(src[10]),
    .sound_card_hit(src[9:8]), .legacy_io_hit(src[7:4]),
    .ide_hit(src[3:0]), .device_trap_allow(dta), .pirq_n(pirq_n),
    .sys_mgmt_interrupt_n(smi_n), .fwd_inhibit(fwd));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input itam_word_t s,
    input itam_word_t e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input string n, input itam_word_t ofs,
    input itam_word_t e);
    u_host.acc(1'b0, ofs, 16'h0000, 2'h3, q, a);
    chk(n, q, e);
    chk("ack", {15'h0, a}, 16'h0001);
  endtask
  task automatic wr(input itam_word_t ofs, input itam_word_t d,
    input logic [1:0] be);
    u_host.acc(1'b1, ofs, d, be, q, a);
  endtask
  // Pulse hit sources for one cycle
  task automatic hit(input logic [12:0] s, input itam_mon_t m);
    @(posedge mclk);
    #1;
    src = s;
    mon = m;
    @(posedge mclk);
    #1;
    src = 13'h0;
    mon = 4'h0;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("smi idle", {15'h0, smi_n}, 16'h0001);
    rd("mon rst", `ITAM_MON_OFS, `ITAM_MON_RST);
    rd("act rst", `ITAM_ACT_OFS, `ITAM_ACT_RST);
  endtask
  task automatic t_trap();
    itam_word_t f;
    wr(`ITAM_MON_OFS, 16'h0FFF, 2'h3);
    rd("allow rw", `ITAM_MON_OFS, 16'h0F00);
    wr(`ITAM_MON_OFS, 16'h0000, 2'h1);
    rd("allow lane", `ITAM_MON_OFS, 16'h0F00);
    for (int i = 0; i < 4; i++) begin
      f = 16'h1000 << i;
      hit(13'h0, 4'h1 << i);
      @(posedge mclk);
      #1;
      chk("smi set", {15'h0, smi_n}, 16'h0000);
      rd("trap flag", `ITAM_MON_OFS, f | 16'h0F00);
      wr(`ITAM_MON_OFS, f | 16'h0F00, 2'h3);
      @(posedge mclk);
      #1;
      chk("smi clr", {15'h0, smi_n}, 16'h0001);
    end
    wr(`ITAM_MON_OFS, 16'h0000, 2'h3);
    hit(13'h0, 4'hF);
    repeat (2) @(posedge mclk);
    #1;
    chk("smi off", {15'h0, smi_n}, 16'h0001);
    rd("no flag", `ITAM_MON_OFS, 16'h0000);
  endtask
  task automatic t_act();
    int b;
    for (int k = 0; k < 13; k++) begin
      b = (k < 4) ? k : (k < 8) ? 5 : (k < 10) ? 10 : k + 1;
      hit(13'h1 << k, 4'h0);
      rd("act set", `ITAM_ACT_OFS, 16'h1 << b);
      wr(`ITAM_ACT_OFS, ~(16'h1 << b), 2'h3);
      rd("act kept", `ITAM_ACT_OFS, 16'h1 << b);
      wr(`ITAM_ACT_OFS, 16'hFFFF, 2'h3);
      rd("act clr", `ITAM_ACT_OFS, 16'h0000);
    end
  endtask
  task automatic t_pirq();
    for (int p = 0; p < 8; p++) begin
      @(posedge mclk);
      #1;
      pirq_n = ~(8'h1 << p);
      repeat (3) @(posedge mclk);
      #1;
      pirq_n = 8'hFF;
      repeat (3) @(posedge mclk);
      rd("pirq", `ITAM_ACT_OFS, 16'h40 << (p % 4));
      wr(`ITAM_ACT_OFS, 16'hFFFF, 2'h3);
    end
  endtask
  task automatic t_misc();
    u_host.acc(1'b0, 16'h0042, 16'h0000, 2'h3, q, a);
    chk("unmapped", {q[15:1], a}, 16'h0000);
    @(posedge mclk);
    #1;
    dta = 16'h2000;
    src = 13'h1000;
    #1;
    chk("fwd on", {15'h0, fwd}, 16'h0001);
    @(posedge mclk);
    #1;
    dta = 16'h0000;
    #1;
    chk("fwd off", {15'h0, fwd}, 16'h0000);
    @(posedge mclk);
    #1;
    src = 13'h0;
    hit(13'h0801, 4'h0);
    wr(`ITAM_ACT_OFS, 16'hFFFF, 2'h1);
    rd("lane", `ITAM_ACT_OFS, 16'h3000);
    wr(`ITAM_ACT_OFS, 16'hFFFF, 2'h3);
  endtask
  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Hang guard, about sixty times the expected run
  initial begin
    #80000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    base = 16'h0400;
    dta = 16'h0000;
    mon = 4'h0;
    src = 13'h0;
    pirq_n = 8'hFF;
    num_errors = 0;
    num_checks = 0;
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    t_trap();
    t_act();
    t_pirq();
    t_misc();
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** logic/itam_pkg.sv ***
// Purpose: Shared types of the trap/activity monitor
// Assumes: 16-bit registers, four monitors
// Notes: Numbers live in itam_regs.svh
package itam_pkg;
  typedef logic [15:0] itam_word_t;
  typedef logic [3:0] itam_mon_t;
endpackage

// *** logic/itam_regs.svh ***
// Purpose: Offsets, field positions, reset values for the trap/activity monitor
// Assumes: Offsets are relative to the power-management I/O base
// Notes: Included by its bare name
`ifndef ITAM_REGS_SVH
`define ITAM_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ITAM_MON_OFS 16'h0040
`define ITAM_ACT_OFS 16'h0044

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ITAM_MON_FLAG_LSB 12
`define ITAM_MON_ALLOW_LSB 8
`define ITAM_ACT_FM 13
`define ITAM_ACT_KBC 12
`define ITAM_ACT_MUSIC 11
`define ITAM_ACT_SOUND 10
`define ITAM_ACT_PIRQ_LSB 6
`define ITAM_ACT_LEGACY 5
`define ITAM_ACT_IDE_LSB 0
`define ITAM_ACT_VALID 16'h3FEF
`define ITAM_TRAP_VALID 16'h3C2F

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ITAM_MON_RST 16'h0000
`define ITAM_ACT_RST 16'h0000

`endif

// *** logic/itam_sticky.sv ***
// Purpose: Bank of sticky flags, set by hardware, cleared by writing one
// Assumes: Set and clear come from logic on mclk
// Notes: A set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module itam_sticky #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Events and clears
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Flag state
  output logic [W-1:0] flag_r
);
  wire logic [W-1:0] flag_nxt;

  // Set beats clear so no event is lost
  assign flag_nxt = set | (flag_r & ~clr);

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Width sanity, refused at elaboration
  if (W < 1) begin
    $error("itam_sticky: W must be at least 1");
  end

  a_set_wins: assert property (@(posedge mclk)
    disable iff (rst) (set != '0) |=>
    ((flag_r & $past(set)) == $past(set)))
    else $error("sticky set was lost");
endmodule
`default_nettype wire

// *** logic/itam_top.sv ***
// Purpose: Monitor trap flags and device activity flags with SMI request
// Assumes: Range hits are one-cycle pulses decoded on mclk; PCI
//          interrupt lines arrive from pins and are synchronised here
// Notes: Registers sit at the power-management I/O base plus offset
`timescale 1ns/1ps
`default_nettype none
`include "itam_regs.svh"
module itam_top #(
  parameter int NPIRQ = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host I/O cycles
  input wire itam_pkg::itam_word_t power_mgmt_io_base,
  input wire itam_pkg::itam_word_t io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [1:0] io_be,
  input wire itam_pkg::itam_word_t io_wdata,
  output itam_pkg::itam_word_t io_rdata_r,
  output logic io_ack_r,
  // Decoded range hits, one-cycle pulses
  input wire itam_pkg::itam_mon_t monitor_hit,
  input wire logic fm_sound_hit,
  input wire logic keyboard_ctrl_hit,
  input wire logic music_port_hit,
  input wire logic [1:0] sound_card_hit,
  input wire logic [3:0] legacy_io_hit,
  input wire logic [3:0] ide_hit,
  // Device trap enables, same layout as activity flags
  input wire itam_pkg::itam_word_t device_trap_allow,
  // PCI interrupt pins A..H, active low
  input wire logic [NPIRQ-1:0] pirq_n,
  // Results
  output logic sys_mgmt_interrupt_n,
  output logic fwd_inhibit
);
  import itam_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  logic [NPIRQ-1:0] pirq_meta_r;
  logic [NPIRQ-1:0] pirq_sync_r;

  // Two flops before any logic sees the pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pirq_meta_r <= '1;
      pirq_sync_r <= '1;
    end else begin
      pirq_meta_r <= pirq_n;
      pirq_sync_r <= pirq_meta_r;
    end
  end

  // Only four pairs of lines are served
  if (NPIRQ != 8) begin
    $error("itam_top: NPIRQ must be 8, four pairs");
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire itam_word_t mon_addr;
  wire itam_word_t act_addr;
  wire logic mon_sel;
  wire logic act_sel;
  wire itam_word_t be_mask;
  wire itam_word_t wmask;

  assign mon_addr = power_mgmt_io_base + `ITAM_MON_OFS;
  assign act_addr = power_mgmt_io_base + `ITAM_ACT_OFS;
  assign mon_sel = (io_addr == mon_addr);
  assign act_sel = (io_addr == act_addr);
  assign be_mask = {{8{io_be[1]}}, {8{io_be[0]}}};
  assign wmask = io_wdata & be_mask;

  // ----------------------------------------------------------------------
  // Monitor trap allow and flags
  // ----------------------------------------------------------------------
  logic [3:0] allow_r;
  wire logic [3:0] allow_nxt;
  wire logic allow_we;
  wire logic [3:0] trap_set;
  wire logic [3:0] trap_clr;
  wire logic [3:0] trap_flag;

  // Allow bits live in the upper byte lane
  assign allow_we = io_wr & mon_sel & io_be[1];
  assign allow_nxt = allow_we ?
    io_wdata[`ITAM_MON_ALLOW_LSB +: 4] : allow_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      allow_r <= 4'h0;
    end else begin
      allow_r <= allow_nxt;
    end
  end

  // Only an allowed monitor access traps and flags
  assign trap_set = monitor_hit & allow_r;
  assign trap_clr = (io_wr & mon_sel) ?
    wmask[`ITAM_MON_FLAG_LSB +: 4] : 4'h0;

  itam_sticky #(.W(4)) u_trap (
    .mclk(mclk),
    .rst(rst),
    .set(trap_set),
    .clr(trap_clr),
    .flag_r(trap_flag)
  );

  // ----------------------------------------------------------------------
  // Activity flags
  // ----------------------------------------------------------------------
  wire itam_word_t act_set;
  wire itam_word_t act_clr;
  wire itam_word_t act_flag;
  wire logic [3:0] pair_active;

  // Pair n is line n or line n+4, low meaning active
  assign pair_active = ~pirq_sync_r[3:0] | ~pirq_sync_r[7:4];

  // Set regardless of any enable; reserved bits never set
  assign act_set = {
    2'b00,
    fm_sound_hit,
    keyboard_ctrl_hit,
    music_port_hit,
    |sound_card_hit,
    pair_active,
    |legacy_io_hit,
    1'b0,
    ide_hit
  } & `ITAM_ACT_VALID;
  assign act_clr = (io_wr & act_sel) ? wmask : 16'h0000;

  itam_sticky #(.W(16)) u_act (
    .mclk(mclk),
    .rst(rst),
    .set(act_set),
    .clr(act_clr),
    .flag_r(act_flag)
  );

  // ----------------------------------------------------------------------
  // Forwarding block and SMI request
  // ----------------------------------------------------------------------
  wire logic smi_nxt;
  logic smi_r;

  // Combinational so the cycle is held back in the same clock; PCI pair
  // bits carry no trap range, so their enables are masked off
  assign fwd_inhibit =
    |(act_set & device_trap_allow & `ITAM_TRAP_VALID);
  // Request stands while any trap flag stays set
  assign smi_nxt = |trap_flag;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      smi_r <= 1'b0;
    end else begin
      smi_r <= smi_nxt;
    end
  end
  assign sys_mgmt_interrupt_n = ~smi_r;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  wire itam_word_t mon_view;
  wire itam_word_t rd_mux;
  wire logic ack_nxt;

  // Low byte of the monitor register is reserved and reads zero
  assign mon_view = {trap_flag, allow_r, 8'h00};
  assign rd_mux = mon_sel ? mon_view :
                  act_sel ? act_flag : 16'h0000;
  assign ack_nxt = (io_rd | io_wr) & (mon_sel | act_sel);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      io_rdata_r <= `ITAM_MON_RST;
      io_ack_r <= 1'b0;
    end else begin
      io_rdata_r <= io_rd ? rd_mux : 16'h0000;
      io_ack_r <= ack_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_trap_sets: assert property (@(posedge mclk)
    disable iff (rst) ((monitor_hit & allow_r) != 4'h0) |=>
    ((trap_flag & $past(monitor_hit & allow_r)) != 4'h0))
    else $error("allowed trap did not flag");

  a_trap_blocked: assert property (@(posedge mclk)
    disable iff (rst)
    ((trap_flag & ~$past(trap_flag) & ~$past(monitor_hit & allow_r))
    == 4'h0))
    else $error("trap flag rose without allowed hit");

  a_smi_follows: assert property (@(posedge mclk)
    disable iff (rst) (trap_flag != 4'h0) |=> !sys_mgmt_interrupt_n)
    else $error("SMI not requested for trap flag");

  a_smi_quiet: assert property (@(posedge mclk)
    disable iff (rst) (trap_flag == 4'h0) |=> sys_mgmt_interrupt_n)
    else $error("SMI requested with no trap flag");

  a_allow_write: assert property (@(posedge mclk)
    disable iff (rst) (io_wr && mon_sel && io_be[1]) |=>
    (mon_view[11:8] == $past(io_wdata[11:8])))
    else $error("allow bits not written");

  a_allow_keep: assert property (@(posedge mclk)
    disable iff (rst) (io_wr && mon_sel && !io_be[1]) |=> $stable(allow_r))
    else $error("allow bits changed without their lane");

  a_trap_clear: assert property (@(posedge mclk)
    disable iff (rst) (io_wr && mon_sel && io_be[1] &&
    ((monitor_hit & allow_r) == 4'h0)) |=>
    ((trap_flag & $past(io_wdata[`ITAM_MON_FLAG_LSB +: 4])) == 4'h0))
    else $error("trap flag not cleared by one");

  a_w1c_clear: assert property (@(posedge mclk)
    disable iff (rst)
    (io_wr && act_sel && io_be == 2'b11 && act_set == 16'h0000) |=>
    ((act_flag & $past(io_wdata)) == 16'h0000))
    else $error("write one did not clear");

  a_w1c_keep: assert property (@(posedge mclk)
    disable iff (rst) (io_wr && act_sel) |=>
    ((act_flag & $past(act_flag & ~wmask)) == $past(act_flag & ~wmask)))
    else $error("write zero changed a flag");

  a_ack_pulse: assert property (@(posedge mclk)
    disable iff (rst) ((io_rd || io_wr) && (mon_sel || act_sel)) |=>
    io_ack_r)
    else $error("mapped access not acknowledged");

  a_unmapped_quiet: assert property (@(posedge mclk)
    disable iff (rst) ((io_rd || io_wr) && !mon_sel && !act_sel) |=>
    (!io_ack_r && io_rdata_r == 16'h0000))
    else $error("unmapped access answered");

  a_read_data: assert property (@(posedge mclk)
    disable iff (rst) (io_rd && act_sel) |=>
    (io_rdata_r == $past(act_flag)))
    else $error("activity read data wrong");

  a_reserved_zero: assert property (@(posedge mclk)
    disable iff (rst) io_ack_r |->
    (act_flag[15:14] == 2'b00 && act_flag[4] == 1'b0 &&
    mon_view[7:0] == 8'h00))
    else $error("reserved bit not zero");

  a_pirq_pair: assert property (@(posedge mclk)
    disable iff (rst)
    (!pirq_n[0] && !$past(pirq_n[0]) && !$past(pirq_n[0], 2)) |=>
    act_flag[`ITAM_ACT_PIRQ_LSB])
    else $error("PCI pair activity lost");

  a_fwd_block: assert property (@(posedge mclk)
    disable iff (rst) (fm_sound_hit && device_trap_allow[`ITAM_ACT_FM]) |->
    fwd_inhibit)
    else $error("trapped cycle forwarded");

  a_kbc_act: assert property (@(posedge mclk)
    disable iff (rst) keyboard_ctrl_hit |=> act_flag[`ITAM_ACT_KBC])
    else $error("keyboard activity lost");

  a_music_act: assert property (@(posedge mclk)
    disable iff (rst) music_port_hit |=> act_flag[`ITAM_ACT_MUSIC])
    else $error("music port activity lost");

  a_fm_act: assert property (@(posedge mclk)
    disable iff (rst) fm_sound_hit |=> act_flag[`ITAM_ACT_FM])
    else $error("FM sound activity lost");

  a_sound_act: assert property (@(posedge mclk)
    disable iff (rst) (sound_card_hit != 2'b00) |=>
    act_flag[`ITAM_ACT_SOUND])
    else $error("sound card activity lost");

  a_legacy_act: assert property (@(posedge mclk)
    disable iff (rst) (legacy_io_hit != 4'h0) |=>
    act_flag[`ITAM_ACT_LEGACY])
    else $error("legacy I/O activity lost");

  a_ide_act: assert property (@(posedge mclk)
    disable iff (rst) (ide_hit != 4'h0) |=>
    ((act_flag[`ITAM_ACT_IDE_LSB +: 4] & $past(ide_hit)) == $past(ide_hit)))
    else $error("IDE activity lost");
endmodule
`default_nettype wire
